// file: tb/ppm_ext_mem.sv
// External memory model with address latches, standing on the far side of the port.
`timescale 1ns/1ps
module ppm_ext_mem
(
  // Clock
  input  wire logic        sys_clk,
  // Port pins
  input  wire logic [1:0]  bus_mux_select,
  input  wire logic [15:0] port_address_lines,
  input  wire logic [15:0] port_data_lines,
  input  wire logic        read_strobe_pin,
  input  wire logic        write_strobe_pin,
  input  wire logic        strobe_low,
  input  wire logic        enable_mode,
  output logic [15:0]      mem_data
);
  // ------------------------------------------------------------
  // Latches, storage and read drive
  // ------------------------------------------------------------
  logic [15:0] mem [16384];
  logic [7:0]  lo_reg;
  logic [15:0] hi_reg;
  logic [15:0] last_reg;
  logic [13:0] addr;
  logic        rd_en;
  logic        wr_en;

  assign rd_en = (read_strobe_pin ^ strobe_low) && (!enable_mode || (write_strobe_pin ^ strobe_low));
  assign wr_en = (write_strobe_pin ^ strobe_low) && !(enable_mode && (read_strobe_pin ^ strobe_low));

  // Each latch takes the bus only while its strobe stands.
  always_ff @(posedge sys_clk)
  begin
    if (port_address_lines[0] && bus_mux_select != 2'h0) lo_reg <= port_data_lines[7:0];
    if (port_address_lines[1] && bus_mux_select[1]) hi_reg <= port_data_lines;
    if (wr_en) mem[addr] <= port_data_lines;
    if (rd_en) last_reg <= mem[addr];
  end

  always_comb
  begin
    case (bus_mux_select)
      2'h0:    addr = port_address_lines[13:0];
      2'h1:    addr = {port_address_lines[13:8], lo_reg};
      2'h2:    addr = {hi_reg[5:0], lo_reg};
      default: addr = hi_reg[13:0];
    endcase
  end

  // A released bus shows the inverse of its last value, so stale data cannot pass.
  assign mem_data = rd_en ? mem[addr] : ~last_reg;
endmodule // ppm_ext_mem

// file: tb/tb_ppm_top.sv
// Self-checking testbench for the parallel port pin multiplexer.
`timescale 1ns/1ps
module tb_ppm_top;
  // ------------------------------------------------------------
  // Signals
  // ------------------------------------------------------------
  logic        sys_clk = 1'b0;
  logic        reset = 1'b1;
  logic        watchdog_reset = 1'b0;
  logic        module_on = 1'b1;
  logic [1:0]  bus_mux_select = 2'h0;
  logic [1:0]  op_mode = ppm_pkg::MODE_MASTER2;
  logic        wide_data_select = 1'b1;
  logic [15:0] address_pin_enables = 16'h3fff;
  logic        req_valid = 1'b0;
  logic        req_write = 1'b0;
  logic [15:0] req_addr = 16'h0000;
  logic [15:0] req_wdata = 16'h0000;
  logic        dma_valid = 1'b0;
  logic        dma_write = 1'b0;
  logic [15:0] dma_wdata = 16'h0000;
  logic        irq_flag_clear = 1'b0;
  logic [1:0]  irq_mode_select = ppm_pkg::IRQ_EVERY_BYTE;
  logic        cs_enable = 1'b0, ctl_active_high = 1'b1;
  logic [15:0] slave_data = 16'h0000;
  logic        slave_cs_in = 1'b0;
  logic        slave_rd_in = 1'b0;
  logic        slave_wr_in = 1'b0;
  logic        req_ready, dma_ready, port_irq_flag, busy, read_strobe_pin, write_strobe_pin, strobe_pins_own;
  logic [15:0] data_input_register, port_address_lines, port_address_own, port_data_lines;
  logic [15:0] port_data_oe, port_data_own, mem_data, port_data_in, a0, a1, d;
  logic [31:0] seed = 32'ha5714a91;
  logic [31:0] tmp;
  logic [15:0] model [int];
  logic [15:0] own_exp [4] = '{16'h3fff, 16'h3f01, 16'h0003, 16'h0003};
  int          lat [4] = '{2, 3, 4, 3};
  int          err_total = 0;
  int          comparisons = 0;
  int          cycles = 0;

  assign port_data_in = op_mode[1] ? mem_data : slave_data;
  always #2.5 sys_clk = ~sys_clk;

  ppm_top i_ppm_top
  (
    .sys_clk(sys_clk), .reset(reset), .watchdog_reset(watchdog_reset), .module_on(module_on),
    .bus_mux_select(bus_mux_select), .op_mode(op_mode), .wide_data_select(wide_data_select),
    .irq_mode_select(irq_mode_select), .address_pin_enables(address_pin_enables),
    .cs_one_enable(cs_enable), .cs_two_enable(cs_enable), .ctl_active_high(ctl_active_high),
    .req_valid(req_valid), .req_write(req_write), .req_addr(req_addr), .req_wdata(req_wdata),
    .req_ready(req_ready), .dma_valid(dma_valid), .dma_write(dma_write), .dma_wdata(dma_wdata),
    .dma_ready(dma_ready), .data_input_register(data_input_register), .port_irq_flag(port_irq_flag),
    .irq_flag_clear(irq_flag_clear), .busy(busy), .port_address_lines(port_address_lines),
    .port_address_own(port_address_own), .port_data_in(port_data_in), .port_data_lines(port_data_lines),
    .port_data_oe(port_data_oe), .port_data_own(port_data_own), .read_strobe_pin(read_strobe_pin),
    .write_strobe_pin(write_strobe_pin), .strobe_pins_own(strobe_pins_own), .slave_cs_in(slave_cs_in),
    .slave_rd_in(slave_rd_in), .slave_wr_in(slave_wr_in)
  );

  ppm_ext_mem i_ppm_ext_mem
  (
    .sys_clk(sys_clk), .bus_mux_select(bus_mux_select), .port_address_lines(port_address_lines),
    .port_data_lines(port_data_lines), .read_strobe_pin(read_strobe_pin),
    .write_strobe_pin(write_strobe_pin), .strobe_low(!ctl_active_high),
    .enable_mode(op_mode == ppm_pkg::MODE_MASTER1), .mem_data(mem_data)
  );

  // ------------------------------------------------------------
  // Tasks
  // ------------------------------------------------------------
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  task automatic step();
    @(posedge sys_clk);
    #1;
  endtask

  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      err_total++;
      $display("unexpected %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic close_out();
    $display("comparisons %0d err_total %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // One port transfer; the address is the one the pins must show, also for DMA.
  task automatic xfer(input logic dma, input logic wr, input logic [15:0] a, input logic [15:0] dv,
                      input int exp_lat);
    int n;
    logic [1:0] sp;
    n = 0;
    while ((dma ? dma_ready : req_ready) !== 1'b1 && n < 50)
    begin
      step();
      n++;
    end
    req_write = wr;
    dma_write = wr;
    req_addr = a;
    req_wdata = dv;
    dma_wdata = dv;
    req_valid = ~dma;
    dma_valid = dma;
    step();
    req_valid = 1'b0;
    dma_valid = 1'b0;
    n = 0;
    while (busy === 1'b1 && n < 20)
    begin
      if (n == 0 && bus_mux_select != ppm_pkg::MUX_DEMUX)
      begin
        check("address byte", {8'h00, port_data_lines[7:0]}, {8'h00, a[7:0]});
        check("latch low", {15'h0000, port_address_lines[0]}, 16'h0001);
      end
      if (n == 0 && bus_mux_select == ppm_pkg::MUX_DEMUX)
      begin
        sp = {read_strobe_pin, write_strobe_pin} ^ {2{!ctl_active_high}};
        check("strobes", {14'h0, sp}, {14'h0, !wr, op_mode[0] | wr});
        check("data oe", port_data_oe, wr ? 16'hffff : 16'h0000);
        if (cs_enable)
          check("cs", {14'h0, port_address_lines[15:14]}, {14'h0, {2{ctl_active_high}}});
      end
      n++;
      step();
    end
    check("busy cycles", n[15:0], exp_lat[15:0]);
  endtask

  always @(posedge sys_clk)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      err_total++;
      close_out();
    end
  end

  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial
  begin
    repeat (2) step();
    reset = 1'b0;
    for (int m = 0; m < 4; m++)
    begin
      op_mode = m[1:0];
      step();
      check("cpu ready", {15'h0000, req_ready}, {15'h0000, m[1]});
      check("dma ready", {15'h0000, dma_ready}, {15'h0000, m[1]});
      check("data own", port_data_own, m[1] ? 16'hffff : 16'h00ff);
    end
    op_mode = ppm_pkg::MODE_MASTER2;
    wide_data_select = 1'b0;
    step();
    check("narrow own", port_data_own, 16'h00ff);
    wide_data_select = 1'b1;
    module_on = 1'b0;
    step();
    check("off ready", {15'h0000, req_ready}, 16'h0000);
    module_on = 1'b1;
    for (int x = 0; x < 4; x++)
    begin
      bus_mux_select = x[1:0];
      step();
      check("addr own", port_address_own, own_exp[x]);
      tmp = xs();
      a0 = {2'b00, tmp[13:0]};
      a1 = a0 ^ 16'h0155;
      tmp = xs();
      d = tmp[15:0];
      xfer(1'b0, 1'b1, a0, d, lat[x]);
      model[a0] = d;
      tmp = xs();
      d = tmp[15:0];
      xfer(1'b0, 1'b1, a1, d, lat[x]);
      model[a1] = d;
      xfer(1'b0, 1'b0, a0, 16'h0000, lat[x]);
      check("read back", data_input_register, model[a0]);
      check("irq flag", {15'h0000, port_irq_flag}, 16'h0001);
    end
    irq_flag_clear = 1'b1;
    step();
    irq_flag_clear = 1'b0;
    step();
    check("flag clear", {15'h0000, port_irq_flag}, 16'h0000);
    tmp = xs();
    d = tmp[15:0];
    xfer(1'b1, 1'b1, a0, d, lat[3]);
    model[a0] = d;
    check("dma flag", {15'h0000, port_irq_flag}, 16'h0001);
    xfer(1'b1, 1'b0, a0, 16'h0000, lat[3]);
    check("dma read", data_input_register, model[a0]);
    watchdog_reset = 1'b1;
    step();
    watchdog_reset = 1'b0;
    step();
    check("wdt data", data_input_register, ppm_pkg::RESET_DATA);
    check("wdt flag", {15'h0000, port_irq_flag}, 16'h0000);
    check("wdt busy", {15'h0000, busy}, 16'h0000);
    op_mode = ppm_pkg::MODE_MASTER1;
    ctl_active_high = 1'b0;
    cs_enable = 1'b1;
    irq_mode_select = 2'h0;
    bus_mux_select = ppm_pkg::MUX_DEMUX;
    step();
    check("cs idle", {14'h0, port_address_lines[15:14]}, 16'h0003);
    check("strobe own", {15'h0, strobe_pins_own}, 16'h0001);
    xfer(1'b0, 1'b1, a1, ~d, lat[0]);
    model[a1] = ~d;
    xfer(1'b0, 1'b0, a1, 16'h0000, lat[0]);
    check("mode 1 read", data_input_register, model[a1]);
    check("irq off", {15'h0, port_irq_flag}, 16'h0000);
    ctl_active_high = 1'b1;
    irq_mode_select = ppm_pkg::IRQ_EVERY_BYTE;
    op_mode = ppm_pkg::MODE_SLAVE_LEGACY;
    tmp = xs();
    slave_data = tmp[15:0];
    slave_cs_in = 1'b1;
    slave_rd_in = 1'b1;
    step();
    slave_rd_in = 1'b0;
    slave_wr_in = 1'b1;
    repeat (2) step();
    slave_wr_in = 1'b0;
    slave_cs_in = 1'b0;
    step();
    check("slave byte", data_input_register, {8'h00, slave_data[7:0]});
    check("slave flag", {15'h0, port_irq_flag}, 16'h0001);
    close_out();
  end
endmodule // tb_ppm_top

// file: verilog/ppm_phase_if.sv
// Interface carrying the bus phase decision between sequencer and pin mapper.
`timescale 1ns/1ps
interface ppm_phase_if;
  logic        phase_addr_low;
  logic        phase_addr_high;
  logic        phase_data;
  logic        phase_write;
  logic [15:0] addr;
  logic [15:0] wdata;

  modport seq (output phase_addr_low, output phase_addr_high, output phase_data,
               output phase_write, output addr, output wdata);
  modport pins (input phase_addr_low, input phase_addr_high, input phase_data,
                input phase_write, input addr, input wdata);
endinterface

// file: verilog/ppm_pin_map.sv
// Pin ownership and output mapping for the parallel port.
`timescale 1ns/1ps
module ppm_pin_map
(
  // Configuration
  input  wire logic [1:0]  bus_mux_select,
  input  wire logic [1:0]  op_mode,
  input  wire logic        wide_data_select,
  input  wire logic [15:0] address_pin_enables,
  input  wire logic        cs_one_enable,
  input  wire logic        cs_two_enable,
  input  wire logic        cs_active_high,
  input  wire logic        module_on,
  // Phase
  ppm_phase_if.pins        ph,
  // Pins
  output logic [15:0]      addr_out,
  output logic [15:0]      addr_own,
  output logic [15:0]      data_out,
  output logic [15:0]      data_oe,
  output logic [15:0]      data_own
);

  logic master;
  logic slave;
  logic active;
  logic cs_level;

  assign master   = module_on && (op_mode == ppm_pkg::MODE_MASTER1 || op_mode == ppm_pkg::MODE_MASTER2);
  assign slave    = module_on && !master;
  assign active   = ph.phase_addr_low || ph.phase_addr_high || ph.phase_data;
  assign cs_level = cs_active_high ? active : !active;

  // ---------------------------------------------------------------
  // Address pins
  // ---------------------------------------------------------------
  always_comb
  begin
    addr_out = ph.addr;
    addr_own = master ? address_pin_enables : 16'h0000; // RL13
    if (bus_mux_select == ppm_pkg::MUX_PARTIAL)
    begin
      addr_own[ppm_pkg::ADDR_LO_TOP:1] = '0; // RL14
      addr_out[ppm_pkg::PIN_LATCH_LOW] = ph.phase_addr_low; // RL14 RL20
    end
    else if (bus_mux_select == ppm_pkg::MUX_FULL8 || bus_mux_select == ppm_pkg::MUX_FULL16)
    begin
      addr_own[ppm_pkg::ADDR_MID_TOP:2] = '0; // RL15
      addr_out[ppm_pkg::PIN_LATCH_LOW]  = ph.phase_addr_low; // RL15 RL20
      addr_out[ppm_pkg::PIN_LATCH_HIGH] = (bus_mux_select == ppm_pkg::MUX_FULL8) ?
                                          ph.phase_addr_high : ph.phase_addr_low; // RL15 RL20
    end
    if (cs_one_enable)
      addr_out[ppm_pkg::PIN_CS_ONE] = cs_level; // RL18
    if (cs_two_enable)
      addr_out[ppm_pkg::PIN_CS_TWO] = cs_level; // RL18
    if (slave)
      addr_own[ppm_pkg::PIN_CS_ONE] = 1'b0; // RL16 chip select becomes an input
  end

  // ---------------------------------------------------------------
  // Data pins
  // ---------------------------------------------------------------
  always_comb
  begin
    data_own = '0;
    data_out = ph.wdata;
    data_oe  = '0;
    if (slave)
      data_own[7:0] = 8'hff; // RL16 RL17
    else if (master)
    begin
      data_own[7:0] = 8'hff;
      if (wide_data_select || bus_mux_select == ppm_pkg::MUX_FULL16)
        data_own[15:8] = 8'hff; // RL6
    end
    if (master && ph.phase_addr_low)
    begin
      if (bus_mux_select == ppm_pkg::MUX_FULL16)
        data_out = ph.addr; // RL5
      else
        data_out = {ph.wdata[15:8], ph.addr[7:0]}; // RL3 RL4
      data_oe = data_own;
    end
    else if (master && ph.phase_addr_high)
    begin
      data_out = {ph.wdata[15:8], 2'h0, ph.addr[13:8]}; // RL4
      if (!cs_one_enable)
        data_out[6] = ph.addr[14];
      data_oe = data_own;
    end
    else if (master && ph.phase_data && ph.phase_write)
      data_oe = data_own; // RL2
  end

endmodule // ppm_pin_map

// file: verilog/ppm_pkg.sv
// Package for the parallel port pin multiplexer: encodings, widths and pin positions.
package ppm_pkg;

  // Bus multiplexing field encodings.
  localparam logic [1:0] MUX_DEMUX   = 2'h0;
  localparam logic [1:0] MUX_PARTIAL = 2'h1;
  localparam logic [1:0] MUX_FULL8   = 2'h2;
  localparam logic [1:0] MUX_FULL16  = 2'h3;

  // Operating mode encodings.
  localparam logic [1:0] MODE_SLAVE_LEGACY = 2'h0;
  localparam logic [1:0] MODE_SLAVE_BUF    = 2'h1;
  localparam logic [1:0] MODE_MASTER2      = 2'h2;
  localparam logic [1:0] MODE_MASTER1      = 2'h3;

  // Interrupt mode encoding for a request on every byte.
  localparam logic [1:0] IRQ_EVERY_BYTE = 2'h1;

  // Widths and pin positions.
  localparam int ADDR_W    = 16;
  localparam int DATA_W    = 16;
  localparam int BYTE_W    = 8;
  localparam int PIN_LATCH_LOW  = 0;
  localparam int PIN_LATCH_HIGH = 1;
  localparam int PIN_CS_ONE     = 14;
  localparam int PIN_CS_TWO     = 15;
  localparam int ADDR_LO_TOP    = 7;
  localparam int ADDR_MID_TOP   = 13;

  // Strobe width of the data phase in clock cycles.
  localparam logic [3:0] DATA_PHASE_CYCLES = 4'h1;

  // Reset values.
  localparam logic [15:0] RESET_ADDR_EN = 16'h0000;
  localparam logic [15:0] RESET_DATA    = 16'h0000;

  typedef enum logic [2:0] {
    PPM_IDLE,
    PPM_ADDR_LOW,
    PPM_ADDR_HIGH,
    PPM_DATA,
    PPM_DONE
  } ppm_state_t;

endpackage

// file: verilog/ppm_top.sv
// Parallel port bus sequencer: mode decode, address phases, DMA pairing and pin ownership.
`timescale 1ns/1ps
// Operation
// RL1 - Watchdog reset restores all registers
// RL2 - Mux 00: separate address and data
// RL3 - Partial mux: low address, then data
// RL4 - Mux 10: low, high address, then data
// RL5 - Mux 11: whole address at once
// RL6 - Narrow width: only data lines 7..0 (mux 11 still owns and drives data lines 15..8)
// RL7 - Mode 10 is master with read/write strobes
// RL8 - Mode 11 uses rw line plus enable
// RL9 - Mode 00 is legacy eight-bit slave
// RL10 - Master DMA accesses become port transfers
// RL11 - Irq mode 01 requests every byte
// RL12 - No DMA in any slave mode
// RL13 - Master drives only enabled address pins
// RL14 - Partial mux: pin 0 latches low
// RL15 - Full mux: pins 0,1 become latches
// RL16 - Slave mode takes cs, strobes, data
// RL17 - Slave uses low data byte only
// RL18 - Chip selects share address lines 15,14
// RL19 - Master sets flag per completed transfer
// RL20 - Latch strobe high only during address
module ppm_top
(
  // Clock and resets
  input  wire logic        sys_clk,
  input  wire logic        reset,
  input  wire logic        watchdog_reset,
  // Configuration
  input  wire logic        module_on,
  input  wire logic [1:0]  bus_mux_select,
  input  wire logic [1:0]  op_mode,
  input  wire logic        wide_data_select,
  input  wire logic [1:0]  irq_mode_select,
  input  wire logic [15:0] address_pin_enables,
  input  wire logic        cs_one_enable,
  input  wire logic        cs_two_enable,
  input  wire logic        ctl_active_high,
  // Transfer requests
  input  wire logic        req_valid,
  input  wire logic        req_write,
  input  wire logic [15:0] req_addr,
  input  wire logic [15:0] req_wdata,
  output logic             req_ready,
  // DMA port on the data input register
  input  wire logic        dma_valid,
  input  wire logic        dma_write,
  input  wire logic [15:0] dma_wdata,
  output logic             dma_ready,
  // Status
  output logic [15:0]      data_input_register,
  output logic             port_irq_flag,
  input  wire logic        irq_flag_clear,
  output logic             busy,
  // Address pins
  output logic [15:0]      port_address_lines,
  output logic [15:0]      port_address_own,
  // Data pins
  input  wire logic [15:0] port_data_in,
  output logic [15:0]      port_data_lines,
  output logic [15:0]      port_data_oe,
  output logic [15:0]      port_data_own,
  // Strobes
  output logic             read_strobe_pin,
  output logic             write_strobe_pin,
  output logic             strobe_pins_own,
  input  wire logic        slave_cs_in,
  input  wire logic        slave_rd_in,
  input  wire logic        slave_wr_in
);

  // ---------------------------------------------------------------
  // Mode decode
  // ---------------------------------------------------------------
  ppm_pkg::ppm_state_t state_reg;
  ppm_pkg::ppm_state_t state_next;
  logic        rst_all;
  logic        is_master;
  logic        is_slave;
  logic        start_cpu;
  logic        start_dma;
  logic        write_reg;
  logic [15:0] addr_reg;
  logic [15:0] wdata_reg;
  logic [3:0]  data_cnt_reg;
  logic        from_dma_reg;
  logic        strobe_act;
  logic        slv_rd_d_reg;
  logic        slv_wr_d_reg;
  logic        slave_edge;
  logic        byte_event;

  assign rst_all   = reset || watchdog_reset; // RL1
  assign is_master = module_on && (op_mode == ppm_pkg::MODE_MASTER1 || op_mode == ppm_pkg::MODE_MASTER2);
  assign is_slave  = module_on && !is_master;

  // DMA has priority over the processor request since it is paced by the byte interrupt.
  assign dma_ready = is_master && state_reg == ppm_pkg::PPM_IDLE; // RL10 RL12
  assign req_ready = is_master && state_reg == ppm_pkg::PPM_IDLE && !dma_valid;
  assign start_dma = dma_valid && dma_ready; // RL10
  assign start_cpu = req_valid && req_ready;
  assign busy      = state_reg != ppm_pkg::PPM_IDLE;

  // ---------------------------------------------------------------
  // Transfer sequencer
  // ---------------------------------------------------------------
  always_comb
  begin
    state_next = state_reg;
    case (state_reg)
      ppm_pkg::PPM_IDLE:
        if (start_dma || start_cpu)
          state_next = (bus_mux_select == ppm_pkg::MUX_DEMUX) ? ppm_pkg::PPM_DATA
                                                               : ppm_pkg::PPM_ADDR_LOW; // RL2 RL3 RL5
      ppm_pkg::PPM_ADDR_LOW:
        state_next = (bus_mux_select == ppm_pkg::MUX_FULL8) ? ppm_pkg::PPM_ADDR_HIGH
                                                             : ppm_pkg::PPM_DATA; // RL4
      ppm_pkg::PPM_ADDR_HIGH:
        state_next = ppm_pkg::PPM_DATA;
      ppm_pkg::PPM_DATA:
        if (data_cnt_reg == ppm_pkg::DATA_PHASE_CYCLES - 4'h1)
          state_next = ppm_pkg::PPM_DONE;
      ppm_pkg::PPM_DONE:
        state_next = ppm_pkg::PPM_IDLE;
      default:
        state_next = ppm_pkg::PPM_IDLE;
    endcase
    if (!is_master)
      state_next = ppm_pkg::PPM_IDLE;
  end

  always_ff @(posedge sys_clk)
  begin
    if (rst_all)
      state_reg <= ppm_pkg::PPM_IDLE; // RL1
    else
      state_reg <= state_next;
  end

  always_ff @(posedge sys_clk)
  begin
    if (rst_all)
      data_cnt_reg <= 4'h0;
    else if (state_reg == ppm_pkg::PPM_DATA)
      data_cnt_reg <= data_cnt_reg + 4'h1;
    else
      data_cnt_reg <= 4'h0;
  end

  always_ff @(posedge sys_clk)
  begin
    if (rst_all)
    begin
      addr_reg     <= ppm_pkg::RESET_ADDR_EN;
      wdata_reg    <= ppm_pkg::RESET_DATA;
      write_reg    <= 1'b0;
      from_dma_reg <= 1'b0;
    end
    else if (start_dma)
    begin
      wdata_reg    <= dma_wdata;
      write_reg    <= dma_write;
      from_dma_reg <= 1'b1;
    end
    else if (start_cpu)
    begin
      addr_reg     <= req_addr;
      wdata_reg    <= req_wdata;
      write_reg    <= req_write;
      from_dma_reg <= 1'b0;
    end
  end

  // Read data is captured at the end of the data phase.
  always_ff @(posedge sys_clk)
  begin
    if (rst_all)
      data_input_register <= ppm_pkg::RESET_DATA;
    else if (state_reg == ppm_pkg::PPM_DATA && !write_reg && state_next == ppm_pkg::PPM_DONE)
      data_input_register <= (wide_data_select && is_master) ? port_data_in
                                                              : {8'h00, port_data_in[7:0]}; // RL6
    else if (is_slave && slv_wr_d_reg == 1'b0 && slave_wr_in && slave_cs_in)
      data_input_register <= {8'h00, port_data_in[7:0]}; // RL17
  end

  // ---------------------------------------------------------------
  // Strobes
  // ---------------------------------------------------------------
  // Master mode 2 drives separate read and write strobes. Master mode 1 drives a
  // read/write level on the first pin and an enable strobe on the second.
  always_comb
  begin
    strobe_act = 1'b0;
    if (state_reg == ppm_pkg::PPM_DATA)
      strobe_act = 1'b1;
    read_strobe_pin  = 1'b0;
    write_strobe_pin = 1'b0;
    if (op_mode == ppm_pkg::MODE_MASTER2)
    begin
      read_strobe_pin  = strobe_act && !write_reg; // RL7
      write_strobe_pin = strobe_act && write_reg; // RL7
    end
    else if (op_mode == ppm_pkg::MODE_MASTER1)
    begin
      read_strobe_pin  = busy && !write_reg; // RL8
      write_strobe_pin = strobe_act; // RL8 enable strobe
    end
    if (!ctl_active_high)
    begin
      read_strobe_pin  = !read_strobe_pin; // RL8
      write_strobe_pin = !write_strobe_pin;
    end
    if (!is_master)
    begin
      read_strobe_pin  = 1'b0;
      write_strobe_pin = 1'b0;
    end
  end

  assign strobe_pins_own = is_master;

  // ---------------------------------------------------------------
  // Slave side and interrupt flag
  // ---------------------------------------------------------------
  always_ff @(posedge sys_clk)
  begin
    if (rst_all)
    begin
      slv_rd_d_reg <= 1'b0;
      slv_wr_d_reg <= 1'b0;
    end
    else
    begin
      slv_rd_d_reg <= slave_rd_in;
      slv_wr_d_reg <= slave_wr_in;
    end
  end

  assign slave_edge = is_slave && slave_cs_in &&
                      ((slave_rd_in && !slv_rd_d_reg) || (slave_wr_in && !slv_wr_d_reg)); // RL9
  assign byte_event = (state_reg == ppm_pkg::PPM_DONE) || slave_edge; // RL19

  // A new byte event in the clearing cycle wins, so no transfer is lost.
  always_ff @(posedge sys_clk)
  begin
    if (rst_all)
      port_irq_flag <= 1'b0;
    else if (byte_event && irq_mode_select == ppm_pkg::IRQ_EVERY_BYTE)
      port_irq_flag <= 1'b1; // RL11 RL19
    else if (irq_flag_clear)
      port_irq_flag <= 1'b0;
  end

  // ---------------------------------------------------------------
  // Pin mapping
  // ---------------------------------------------------------------
  ppm_phase_if ph ();

  assign ph.phase_addr_low  = state_reg == ppm_pkg::PPM_ADDR_LOW;
  assign ph.phase_addr_high = state_reg == ppm_pkg::PPM_ADDR_HIGH;
  assign ph.phase_data      = state_reg == ppm_pkg::PPM_DATA;
  assign ph.phase_write     = write_reg;
  assign ph.addr            = addr_reg;
  assign ph.wdata           = wdata_reg;

  ppm_pin_map u_pin_map
  (
    .bus_mux_select      (bus_mux_select),
    .op_mode             (op_mode),
    .wide_data_select    (wide_data_select),
    .address_pin_enables (address_pin_enables),
    .cs_one_enable       (cs_one_enable),
    .cs_two_enable       (cs_two_enable),
    .cs_active_high      (ctl_active_high),
    .module_on           (module_on),
    .ph                  (ph),
    .addr_out            (port_address_lines),
    .addr_own            (port_address_own),
    .data_out            (port_data_lines),
    .data_oe             (port_data_oe),
    .data_own            (port_data_own)
  );

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  a_demux_no_addr: assert property (@(posedge sys_clk) disable iff (rst_all) // RL2
    (state_reg == ppm_pkg::PPM_IDLE && (start_cpu || start_dma) && bus_mux_select == ppm_pkg::MUX_DEMUX)
      |=> state_reg == ppm_pkg::PPM_DATA)
    else $error("demux transfer took an address phase");
  a_partial_one_cycle: assert property (@(posedge sys_clk) disable iff (rst_all) // RL3
    (state_reg == ppm_pkg::PPM_ADDR_LOW && bus_mux_select == ppm_pkg::MUX_PARTIAL && is_master)
      |-> port_data_lines[7:0] == addr_reg[7:0] ##1 state_reg == ppm_pkg::PPM_DATA)
    else $error("partial mux address phase wrong");
  a_full8_two_cycles: assert property (@(posedge sys_clk) disable iff (rst_all) // RL4
    (state_reg == ppm_pkg::PPM_ADDR_LOW && bus_mux_select == ppm_pkg::MUX_FULL8 && is_master)
      |=> state_reg == ppm_pkg::PPM_ADDR_HIGH ##1 state_reg == ppm_pkg::PPM_DATA)
    else $error("full 8-bit mux must take two address cycles");
  a_full16_addr: assert property (@(posedge sys_clk) disable iff (rst_all) // RL5
    (state_reg == ppm_pkg::PPM_ADDR_LOW && bus_mux_select == ppm_pkg::MUX_FULL16)
      |-> port_data_lines == addr_reg)
    else $error("full 16-bit mux address not on data bus");
  a_narrow_upper: assert property (@(posedge sys_clk) disable iff (rst_all) // RL6
    (!wide_data_select && bus_mux_select != ppm_pkg::MUX_FULL16) |-> port_data_own[15:8] == 8'h00)
    else $error("upper data byte owned in narrow mode");
  a_slave_no_dma: assert property (@(posedge sys_clk) disable iff (rst_all) // RL12
    is_slave |-> !dma_ready && state_reg == ppm_pkg::PPM_IDLE)
    else $error("dma accepted in slave mode");
  a_pin_enable: assert property (@(posedge sys_clk) disable iff (rst_all) // RL13
    (is_master && bus_mux_select == ppm_pkg::MUX_DEMUX) |-> port_address_own == address_pin_enables)
    else $error("address pin driven without enable");
  a_irq_per_byte: assert property (@(posedge sys_clk) disable iff (rst_all) // RL11
    (state_reg == ppm_pkg::PPM_DONE && irq_mode_select == ppm_pkg::IRQ_EVERY_BYTE) |=> port_irq_flag)
    else $error("byte event did not raise flag");
  a_slave_pins: assert property (@(posedge sys_clk) disable iff (rst_all) // RL16
    is_slave |-> port_data_own[7:0] == 8'hff && port_data_own[15:8] == 8'h00 && !port_address_own[14])
    else $error("slave pin ownership wrong");
  a_latch_low_data: assert property (@(posedge sys_clk) disable iff (rst_all) // RL20
    (state_reg == ppm_pkg::PPM_DATA && bus_mux_select != ppm_pkg::MUX_DEMUX) |-> !port_address_lines[0])
    else $error("latch strobe held into data phase");

  c_dma_xfer: cover property (@(posedge sys_clk) start_dma ##[1:4] state_reg == ppm_pkg::PPM_DONE);
  c_full8: cover property (@(posedge sys_clk) state_reg == ppm_pkg::PPM_ADDR_HIGH);
  c_slave_edge: cover property (@(posedge sys_clk) slave_edge);

endmodule // ppm_top
